//--- rtl/frpc_pkg.sv
// Purpose: shared constants and state type for the flash reset and power-on controller
// Assumes: system clock of 200 MHz; all times are turned into cycle counts here
// Notes:   minimum times round up, longest times round down, none below one cycle
package frpc_pkg;

  // system clock rate
  localparam int CLK_MHZ = 200;

  // clear pin minimum low time, a least time
  localparam int CLEAR_PULSE_MIN_US = 1;
  localparam int CLEAR_PULSE_CYC_RAW = CLEAR_PULSE_MIN_US * CLK_MHZ;
  localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_CYC_RAW < 1) ? 1 : CLEAR_PULSE_CYC_RAW;

  // recovery after a reset that hit decode, read, program or status write
  localparam int CLEAR_RECOVERY_TIME_US = 20;
  localparam int RECOVERY_CYC_RAW = CLEAR_RECOVERY_TIME_US * CLK_MHZ;
  localparam int RECOVERY_CYC = (RECOVERY_CYC_RAW < 1) ? 1 : RECOVERY_CYC_RAW;

  // recovery after a reset that hit an erase
  localparam int ERASE_RECOVERY_TIME_MS = 12;
  localparam int ERASE_RECOVERY_CYC_RAW = ERASE_RECOVERY_TIME_MS * 1000 * CLK_MHZ;
  localparam int ERASE_RECOVERY_CYC = (ERASE_RECOVERY_CYC_RAW < 1) ? 1 : ERASE_RECOVERY_CYC_RAW;

  // supply settle delay, a least time; plain default value
  localparam int SUPPLY_SETTLE_DELAY_US = 100;
  localparam int SETTLE_CYC_RAW = SUPPLY_SETTLE_DELAY_US * CLK_MHZ;
  localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

  // timer width, wide enough for the erase recovery
  localparam int TIMER_W = 24;

  // volatile lock bits: count and power-on default (all protected)
  localparam int LOCK_BITS_W = 16;
  localparam logic [LOCK_BITS_W-1:0] LOCK_DEFAULT = 16'hFFFF;

  // controller states
  typedef enum logic [1:0] {
    ST_POWER,
    ST_STANDBY,
    ST_CLEAR,
    ST_RECOVER
  } frpc_state_t;

endpackage

//--- rtl/frpc_timer.sv
// Purpose: loadable down counter used for pulse width, recovery and settle timing
// Assumes: load wins over counting; counter stops at zero
// Notes:   comes out of reset already loaded so a fresh power-up still waits
`timescale 1ns/1ps
module frpc_timer #(
  parameter int               W         = 24,
  parameter logic [W-1:0]     RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // hold at zero, load has priority
  assign cnt_d   = load ? load_val : ((cnt_q == '0) ? cnt_q : cnt_q - {{(W-1){1'b0}}, 1'b1});
  assign expired = (cnt_q == '0);

  // counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= RESET_VAL;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

//--- rtl/frpc_ctrl.sv
// Purpose: reset and power-on state control of a serial flash, behind its pins
// Assumes: RESET is the internal power-on clear, high while supply is under lockout;
//          all inputs synchronous to CLK
// Notes:   commands, flag sets and lock writes are only taken while CMD_ENABLE is high; flag clears are taken whatever CMD_ENABLE is, unless a set wins
`timescale 1ns/1ps
// Behaviour
// - clear pin low for the minimum pulse width causes a full reset.
// - after the reset cycle and recovery the device returns to standby.
// - reset returns write latch, write busy and lock bits to power-on defaults.
// - a program or erase running at reset is aborted.
// - serial output stays high impedance throughout the reset cycle.
// - power-up ends in standby, never in deep power-down.
// - write latch flag is clear at power-up.
// - below lockout the power-on clear holds all logic reset; commands ignored.
// - after supply settle delay the device accepts read commands.
module frpc_ctrl #(
  parameter int CLEAR_CYC     = frpc_pkg::CLEAR_PULSE_CYC,
  parameter int RECOVER_CYC   = frpc_pkg::RECOVERY_CYC,
  parameter int ERASE_REC_CYC = frpc_pkg::ERASE_RECOVERY_CYC,
  parameter int SETTLE_CYC    = frpc_pkg::SETTLE_CYC
) (
  input  wire logic                              CLK,
  input  wire logic                              RESET,
  input  wire logic                              CLEAR_N,
  input  wire logic                              SUPPLY_OK,
  input  wire logic                              ERASE_ACTIVE,
  input  wire logic                              LATCH_SET,
  input  wire logic                              LATCH_CLR,
  input  wire logic                              BUSY_SET,
  input  wire logic                              BUSY_CLR,
  input  wire logic                              LOCK_WE,
  input  wire logic [frpc_pkg::LOCK_BITS_W-1:0]  LOCK_DIN,
  output logic                                   CMD_ENABLE,
  output logic                                   SO_OE_N,
  output logic                                   ABORT_OP,
  output logic                                   VOL_CLEAR,
  output logic                                   RECOVERING,
  output logic                                   WRITE_LATCH_FLAG,
  output logic                                   WRITE_BUSY_FLAG,
  output logic [frpc_pkg::LOCK_BITS_W-1:0]       LOCK_BITS
);

  localparam int TW = frpc_pkg::TIMER_W;
  // the first low sample is taken in standby or recovery, the timer covers the rest, so the
  // CLEAR_CYC-th consecutive low sample confirms; a CLEAR_CYC of 1 still needs two
  localparam int CLR_LOAD = (CLEAR_CYC > 2) ? CLEAR_CYC - 2 : 0;

  frpc_pkg::frpc_state_t state_q;
  frpc_pkg::frpc_state_t state_d;
  logic                 confirmed_q;
  logic                 confirmed_d;
  logic                 erase_hit_q;
  logic                 erase_hit_d;
  logic                 was_rec_q;
  logic                 was_rec_d;
  logic                 confirm_w;
  logic                 tmr_load;
  logic [TW-1:0]        tmr_val;
  logic                 tmr_expired;
  logic [TW-1:0]        rec_val;
  logic                 latch_d;
  logic                 power_w;
  logic                 busy_d;
  logic [frpc_pkg::LOCK_BITS_W-1:0] lock_d;

  // the single timer is shared: each state uses it for one wait only
  frpc_timer #(
    .W         (TW),
    .RESET_VAL (TW'(SETTLE_CYC))
  ) u_timer (
    .clk      (CLK),
    .rst      (RESET),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  // recovery length chosen by what the reset interrupted
  assign rec_val = erase_hit_q ? TW'(ERASE_REC_CYC) : TW'(RECOVER_CYC);

  // sequencing of power-up, clear pulse and recovery
  always_comb begin
    state_d     = state_q;
    confirmed_d = confirmed_q;
    was_rec_d   = was_rec_q;
    confirm_w   = 1'b0;
    tmr_load    = 1'b0;
    tmr_val     = '0;
    if (!SUPPLY_OK) begin
      // supply not at minimum: restart the settle wait
      state_d     = frpc_pkg::ST_POWER;
      confirmed_d = 1'b0;
      tmr_load    = 1'b1;
      tmr_val     = TW'(SETTLE_CYC);
    end else begin
      case (state_q)
        frpc_pkg::ST_POWER: begin
          if (tmr_expired) begin
            state_d = frpc_pkg::ST_STANDBY;
          end
        end
        frpc_pkg::ST_STANDBY, frpc_pkg::ST_RECOVER: begin
          if (!CLEAR_N) begin
            state_d     = frpc_pkg::ST_CLEAR;
            confirmed_d = 1'b0;
            was_rec_d   = (state_q == frpc_pkg::ST_RECOVER);
            tmr_load    = 1'b1;
            tmr_val     = TW'(CLR_LOAD);
          end else if (state_q == frpc_pkg::ST_RECOVER && tmr_expired) begin
            state_d = frpc_pkg::ST_STANDBY;
          end
        end
        frpc_pkg::ST_CLEAR: begin
          if (CLEAR_N) begin
            tmr_load = 1'b1;
            tmr_val  = rec_val;
            if (confirmed_q || was_rec_q) begin
              // a glitch during recovery restarts the recovery wait
              state_d = frpc_pkg::ST_RECOVER;
            end else begin
              state_d = frpc_pkg::ST_STANDBY;
            end
          end else if (tmr_expired && !confirmed_q) begin
            confirm_w   = 1'b1;
            confirmed_d = 1'b1;
          end
        end
        default: begin
          state_d = frpc_pkg::ST_POWER;
        end
      endcase
    end
  end

  // interrupted erase decides the long recovery
  assign erase_hit_d = confirm_w ? (WRITE_BUSY_FLAG && ERASE_ACTIVE) : erase_hit_q;

  // power state (fresh or after a supply dip) keeps the write latch clear
  assign power_w = (state_d == frpc_pkg::ST_POWER);

  // volatile flags: reset wins, then set wins over clear
  assign latch_d = (confirm_w || power_w) ? 1'b0 :
                   (LATCH_SET && CMD_ENABLE) ? 1'b1 :
                   LATCH_CLR ? 1'b0 : WRITE_LATCH_FLAG;
  assign busy_d  = confirm_w ? 1'b0 :
                   (BUSY_SET && CMD_ENABLE) ? 1'b1 :
                   BUSY_CLR ? 1'b0 : WRITE_BUSY_FLAG;
  assign lock_d  = confirm_w ? frpc_pkg::LOCK_DEFAULT :
                   (LOCK_WE && CMD_ENABLE) ? LOCK_DIN : LOCK_BITS;

  // state and flags; power-on clear forces every bit to its default
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q          <= frpc_pkg::ST_POWER;
      confirmed_q      <= 1'b0;
      erase_hit_q      <= 1'b0;
      was_rec_q        <= 1'b0;
      WRITE_LATCH_FLAG <= 1'b0;
      WRITE_BUSY_FLAG  <= 1'b0;
      LOCK_BITS        <= frpc_pkg::LOCK_DEFAULT;
    end else begin
      state_q          <= state_d;
      confirmed_q      <= confirmed_d;
      erase_hit_q      <= erase_hit_d;
      was_rec_q        <= was_rec_d;
      WRITE_LATCH_FLAG <= latch_d;
      WRITE_BUSY_FLAG  <= busy_d;
      LOCK_BITS        <= lock_d;
    end
  end

  // registered status toward the command logic and the output pad
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CMD_ENABLE <= 1'b0;
      SO_OE_N    <= 1'b1;
      ABORT_OP   <= 1'b0;
      VOL_CLEAR  <= 1'b0;
      RECOVERING <= 1'b0;
    end else begin
      CMD_ENABLE <= (state_d == frpc_pkg::ST_STANDBY);
      SO_OE_N    <= (state_d != frpc_pkg::ST_STANDBY);
      ABORT_OP   <= confirm_w && WRITE_BUSY_FLAG;
      VOL_CLEAR  <= confirm_w;
      RECOVERING <= (state_d == frpc_pkg::ST_RECOVER);
    end
  end

  // helper counters watched only by the checks below
  logic [31:0] low_run_q;
  logic [31:0] ok_run_q;
  logic [31:0] rec_run_q;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      low_run_q <= '0;
      ok_run_q  <= '0;
      rec_run_q <= '0;
    end else begin
      low_run_q <= CLEAR_N ? '0 : ((low_run_q == '1) ? low_run_q : low_run_q + 32'h1);
      ok_run_q  <= !SUPPLY_OK ? '0 : ((ok_run_q == '1) ? ok_run_q : ok_run_q + 32'h1);
      // length of the latest recovery wait, held until the next clear pulse
      rec_run_q <= (state_q == frpc_pkg::ST_CLEAR) ? '0 :
                   (state_q == frpc_pkg::ST_RECOVER) ? rec_run_q + 32'h1 : rec_run_q;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_short_low;
    CLEAR_N && CMD_ENABLE ##1 !CLEAR_N [*3] ##1 CLEAR_N;
  endsequence

  sequence s_recover_done;
    state_q == frpc_pkg::ST_RECOVER && tmr_expired && CLEAR_N && SUPPLY_OK;
  endsequence

  // standby regained straight out of a recovery wait, by kind of recovery
  sequence s_erase_rec_end;
    $rose(CMD_ENABLE) && $past(RECOVERING) && erase_hit_q;
  endsequence

  sequence s_plain_rec_end;
    $rose(CMD_ENABLE) && $past(RECOVERING) && !erase_hit_q;
  endsequence

  chk_pulse_width_met: assert property (VOL_CLEAR |-> low_run_q >= 32'(CLEAR_CYC))
    else $error("reset taken before minimum clear pulse width");
  chk_short_glitch: assert property (s_short_low |=> !VOL_CLEAR && CMD_ENABLE)
    else $error("short clear glitch caused a reset");
  chk_volatile_clear: assert property (VOL_CLEAR |-> !WRITE_LATCH_FLAG && !WRITE_BUSY_FLAG
                                       && LOCK_BITS == frpc_pkg::LOCK_DEFAULT)
    else $error("volatile bits not at defaults after reset");
  chk_abort_running: assert property (confirm_w && WRITE_BUSY_FLAG |=> ABORT_OP)
    else $error("running operation not aborted");
  chk_abort_only_busy: assert property (ABORT_OP |-> $past(WRITE_BUSY_FLAG))
    else $error("abort without running operation");
  chk_so_hiz_clear: assert property (!CLEAR_N |=> SO_OE_N && !CMD_ENABLE)
    else $error("serial output enabled during reset cycle");
  chk_recover_standby: assert property (s_recover_done |=> CMD_ENABLE && !RECOVERING)
    else $error("no standby after recovery");
  chk_erase_recovery: assert property ($rose(RECOVERING) && erase_hit_q
                                       |-> !CMD_ENABLE [*8])
    else $error("erase recovery ended too early");
  chk_erase_rec_len: assert property (s_erase_rec_end |-> rec_run_q >= 32'(ERASE_REC_CYC))
    else $error("erase recovery shorter than its count");
  chk_plain_rec_len: assert property (s_plain_rec_end |-> rec_run_q >= 32'(RECOVER_CYC))
    else $error("recovery shorter than its count");
  chk_powerup_standby: assert property (state_q == frpc_pkg::ST_POWER && tmr_expired
                                        && SUPPLY_OK |=> state_q == frpc_pkg::ST_STANDBY)
    else $error("power-up did not end in standby");
  chk_latch_powerup: assert property (state_q == frpc_pkg::ST_POWER |-> !WRITE_LATCH_FLAG)
    else $error("write latch set during power-up");
  chk_settle_before_cmd: assert property (CMD_ENABLE |-> ok_run_q > 32'(SETTLE_CYC))
    else $error("commands enabled before settle delay");

endmodule

//--- sim/frpc_host.sv
// Purpose: host model that drives the clear pin and the flag requests
// Assumes: changes its outputs at the falling clock edge only
// Notes:   issues a request only once the device is ready, or after 500 cycles of waiting
`timescale 1ns/1ps
module frpc_host (
  input  wire logic                             clk,
  input  wire logic                             cmd_en,
  output logic                                  clear_n,
  output logic                                  erase,
  output logic                                  ls,
  output logic                                  lc,
  output logic                                  bs,
  output logic                                  bc,
  output logic                                  lwe,
  output logic [frpc_pkg::LOCK_BITS_W-1:0]      din
);
  initial {clear_n, erase, ls, lc, bs, bc, lwe, din} = {1'b1, 22'h0};

  // hold the pin low for n whole sampled cycles, then release
  task automatic clear_pulse(input int n);
    @(negedge clk) clear_n = 1'b0;
    repeat (n) @(negedge clk);
    clear_n = 1'b1;
  endtask

  // one-cycle request, erase left held as a level; waits first so recovery and settle are respected
  task automatic send(input logic [5:0] v, input logic [15:0] d);
    int k;
    k = 0;
    while (cmd_en !== 1'b1 && k < 500) begin
      @(negedge clk);
      k++;
    end
    {ls, lc, bs, bc, erase, lwe} = v;
    din = d;
    @(negedge clk);
    {ls, lc, bs, bc, lwe} = 5'h0;
    // one idle cycle so a following request never starts in the same time step
    @(negedge clk);
  endtask
endmodule

//--- sim/frpc_ctrl_tb.sv
// Purpose: self-checking bench for the reset and power-on controller
// Assumes: shortened cycle counts so the whole run stays small
// Notes:   pulse outputs are tallied at every rising edge, so no pulse is missed
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module frpc_ctrl_tb;
  localparam int CLR = 8;
  localparam int REC = 12;
  localparam int EREC = 40;
  localparam int SET = 20;
  logic        clk, reset, supply_ok, cmd_en, so_oe_n, abort_op, vol_clear, rec, wlf, wbf;
  logic        clear_n, erase, ls, lc, bs, bc, lwe;
  logic [15:0] din, lock_bits;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_abort = 0;
  int          n_vol = 0;
  int          k, r, a0, v0;

  frpc_host u_host (.clk(clk), .cmd_en(cmd_en), .clear_n(clear_n), .erase(erase), .ls(ls),
    .lc(lc), .bs(bs), .bc(bc), .lwe(lwe), .din(din));
  frpc_ctrl #(.CLEAR_CYC(CLR), .RECOVER_CYC(REC), .ERASE_REC_CYC(EREC), .SETTLE_CYC(SET)) u_dut (
    .CLK(clk), .RESET(reset), .CLEAR_N(clear_n), .SUPPLY_OK(supply_ok), .ERASE_ACTIVE(erase),
    .LATCH_SET(ls), .LATCH_CLR(lc), .BUSY_SET(bs), .BUSY_CLR(bc), .LOCK_WE(lwe),
    .LOCK_DIN(din), .CMD_ENABLE(cmd_en), .SO_OE_N(so_oe_n), .ABORT_OP(abort_op),
    .VOL_CLEAR(vol_clear), .RECOVERING(rec), .WRITE_LATCH_FLAG(wlf), .WRITE_BUSY_FLAG(wbf),
    .LOCK_BITS(lock_bits));

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // pulse tally and hang guard; a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_abort <= n_abort + int'(abort_op === 1'b1);
    n_vol <= n_vol + int'(vol_clear === 1'b1);
    if (cyc > 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // counts cycles until ready, and how many of them showed recovery
  task automatic wait_ready();
    k = 0;
    r = 0;
    while (cmd_en !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
      r += int'(rec === 1'b1);
    end
  endtask

  task automatic t_powerup();
    `CHK({wlf, wbf, so_oe_n, cmd_en}, 4'h2)
    `CHK(lock_bits, 16'hFFFF)
    wait_ready();
    `CHK(k >= SET && k <= SET + 2, 1'b1)
    `CHK(so_oe_n, 1'b0)
  endtask

  task automatic t_clear_busy();
    u_host.send(6'h29, 16'h00A5);
    `CHK({wlf, wbf, lock_bits}, 18'h300A5)
    a0 = n_abort;
    v0 = n_vol;
    fork
      u_host.clear_pulse(CLR);
      begin
        repeat (2) @(negedge clk);
        `CHK({so_oe_n, cmd_en}, 2'h2)
      end
    join
    wait_ready();
    `CHK({n_abort - a0, n_vol - v0}, {32'h1, 32'h1})
    `CHK({wlf, wbf, lock_bits}, 18'h0FFFF)
    `CHK(r >= REC && r <= REC + 1, 1'b1)
    `CHK(so_oe_n, 1'b0)
  endtask

  task automatic t_short_pulse();
    u_host.send(6'h20, 16'h0000);
    v0 = n_vol;
    u_host.clear_pulse(CLR - 1);
    wait_ready();
    u_host.clear_pulse(3);
    wait_ready();
    `CHK({n_vol - v0, wlf}, {32'h0, 1'b1})
    u_host.send(6'h10, 16'h0000);
    `CHK(wlf, 1'b0)
  endtask

  task automatic t_erase();
    u_host.send(6'h0A, 16'h0000);
    a0 = n_abort;
    u_host.clear_pulse(CLR);
    wait_ready();
    `CHK({n_abort - a0, wbf}, {32'h1, 1'b0})
    `CHK(r >= EREC && r <= EREC + 1, 1'b1)
    u_host.send(6'h0A, 16'h0000);
    u_host.send(6'h04, 16'h0000);
    `CHK(wbf, 1'b0)
  endtask

  task automatic t_supply();
    u_host.send(6'h20, 16'h0000);
    @(negedge clk) supply_ok = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({cmd_en, so_oe_n, wlf}, 3'h2)
    reset = 1'b1;
    @(negedge clk) reset = 1'b0;
    supply_ok = 1'b1;
    `CHK({wlf, lock_bits}, 17'h0FFFF)
    wait_ready();
    `CHK(k >= SET && k <= SET + 2, 1'b1)
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    supply_ok = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    t_powerup();
    t_clear_busy();
    t_short_pulse();
    t_erase();
    t_supply();
    stop_test();
  end
endmodule
